// ### hw/nvram_spi_slave_port.v
// Serial memory slave port: pin front end, command decoder and storage.
`timescale 1ns/10ps
`include "nvram_spi_consts.vh"
module nvram_spi_slave_port #(
  parameter DEPTH = 32768,
  parameter AW    = 15
) (
  // Clock and reset.
  input  wire       clk,
  input  wire       rstn,
  // Serial pins.
  input  wire       cs_n,
  input  wire       sck,
  input  wire       si,
  output reg        so_o,
  output reg        so_oe,
  input  wire       pause_n,
  input  wire       wp_n,
  // Status.
  output reg        selected_r,
  output reg        write_latch_r,
  output reg        status_lock_enable_r
);

////////////////////////////////////////////////////////////////////////////////
// Synchronisers; the bench master drives the pause pin high except during a pause.
// Select, pause and protect rest high through reset, so no false select follows.
reg [1:0] cs_s;
reg [1:0] sck_s;
reg [1:0] si_s;
reg [1:0] pz_s;
reg [1:0] wp_s;
reg       sck_d;
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    cs_s  <= 2'h3;
    sck_s <= 2'h0;
    si_s  <= 2'h0;
    pz_s  <= 2'h3;
    wp_s  <= 2'h3;
    sck_d <= 1'b0;
  end
  else
  begin
    cs_s  <= {cs_s[0], cs_n};
    sck_s <= {sck_s[0], sck};
    si_s  <= {si_s[0], si};
    pz_s  <= {pz_s[0], pause_n};
    wp_s  <= {wp_s[0], wp_n};
    sck_d <= sck_s[1];
  end
end

wire cs_act = ~cs_s[1];
wire paused = ~pz_s[1];
// Edges count only while selected and not paused.
wire live   = cs_act & ~paused;
wire rise   = live & sck_s[1] & ~sck_d;
wire fall   = live & ~sck_s[1] & sck_d;

////////////////////////////////////////////////////////////////////////////////
// Storage: array, serial number, status.
reg [7:0] mem    [0:DEPTH-1];
reg [7:0] serial [0:`SERIAL_BYTES-1];
reg [2:0] st_spare_r;
reg [1:0] st_bp_r;

// Bit 0 of the status byte is fixed at zero.
wire [7:0] status_byte = {status_lock_enable_r, st_spare_r, st_bp_r, write_latch_r, 1'b0};
// Status writes blocked when lock enable is set and the protect pin is low.
wire st_write_ok = write_latch_r & ~(status_lock_enable_r & ~wp_s[1]);

////////////////////////////////////////////////////////////////////////////////
// Transfer sequencer.
// A frame is an eight-bit code, then for array and serial-number commands sixteen address bits
// of which the top one is dropped, then data (a fast read puts a dummy byte first). Unknown codes
// park in the idle state until deselect, so a stray byte can never be taken as a later command.
localparam S_CMD  = 3'h0;
localparam S_ADDR = 3'h1;
localparam S_WDAT = 3'h2;
localparam S_RDAT = 3'h3;
localparam S_WST  = 3'h4;
localparam S_RST  = 3'h5;
localparam S_DUMY = 3'h6;
localparam S_IDLE = 3'h7;

reg [2:0]    state_r;
reg [7:0]    op_r;
reg [7:0]    sh_r;
reg [4:0]    cnt_r;
reg [AW-1:0] addr_r;
reg [7:0]    out_r;
reg          cs_d;
reg          mode3_r;
wire [7:0]   sh_nxt = {sh_r[6:0], si_s[1]};

// Read data source for the next byte out.
wire [7:0] rd_byte = (op_r == `OP_RD_SERIAL) ? serial[addr_r[2:0]] : mem[addr_r];

// The serial number resets with the block; retention across reset is not modelled.
integer i;
always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    state_r              <= S_IDLE;
    op_r                 <= 8'h00;
    sh_r                 <= 8'h00;
    cnt_r                <= 5'h00;
    addr_r               <= {AW{1'b0}};
    out_r                <= 8'h00;
    cs_d                 <= 1'b0;
    mode3_r              <= 1'b0;
    so_o                 <= 1'b0;
    so_oe                <= 1'b0;
    selected_r           <= 1'b0;
    write_latch_r        <= 1'b0;
    status_lock_enable_r <= 1'b0;
    st_spare_r           <= 3'h0;
    st_bp_r              <= 2'h0;
    for (i = 0; i < `SERIAL_BYTES; i = i + 1)
      serial[i] <= 8'h00;
  end
  else
  begin
    cs_d       <= cs_act;
    selected_r <= cs_act;
    if (!cs_act)
    begin
      // Deselect ends any transfer; a partial code does nothing.
      state_r <= S_IDLE;
      so_oe   <= 1'b0;
    end
    else if (!cs_d)
    begin
      // Sampling the idle clock level tells mode 3 from mode 0.
      mode3_r <= sck_s[1];
      state_r <= S_CMD;
      cnt_r   <= 5'h00;
      so_oe   <= 1'b0;
    end
    else
    begin
      // Hold keeps every counter frozen, so release resumes in place.
      so_oe <= ~paused & (state_r == S_RDAT || state_r == S_RST);
      if (rise)
      begin
        sh_r  <= sh_nxt;
        cnt_r <= cnt_r + 5'h01;
        case (state_r)
          S_CMD:
          begin
            if (cnt_r == 5'h07)
            begin
              op_r  <= sh_nxt;
              cnt_r <= 5'h00;
              case (sh_nxt)
                `OP_SET_LATCH: begin write_latch_r <= 1'b1; state_r <= S_IDLE; end
                `OP_CLR_LATCH: begin write_latch_r <= 1'b0; state_r <= S_IDLE; end
                `OP_RD_STATUS: begin out_r <= status_byte; state_r <= S_RST; end
                `OP_WR_STATUS: state_r <= S_WST;
                `OP_READ, `OP_FAST_READ, `OP_WRITE, `OP_WR_SERIAL, `OP_RD_SERIAL:
                  state_r <= S_ADDR;
                default: state_r <= S_IDLE;
              endcase
            end
          end
          S_ADDR:
          begin
            addr_r <= {addr_r[AW-2:0], si_s[1]};
            if (cnt_r == 5'h0F)
            begin
              cnt_r <= 5'h00;
              if (op_r == `OP_WRITE || op_r == `OP_WR_SERIAL)
                state_r <= S_WDAT;
              else if (op_r == `OP_FAST_READ)
                state_r <= S_DUMY;
              else
              begin
                state_r <= S_RDAT;
                out_r   <= (op_r == `OP_RD_SERIAL) ?
                           serial[{addr_r[1:0], si_s[1]}] : mem[{addr_r[AW-2:0], si_s[1]}];
              end
            end
          end
          S_DUMY:
          begin
            if (cnt_r == 5'h07)
            begin
              cnt_r   <= 5'h00;
              state_r <= S_RDAT;
              out_r   <= rd_byte;
            end
          end
          S_WDAT:
          begin
            if (cnt_r == 5'h07)
            begin
              cnt_r <= 5'h00;
              // Written at once, no busy period.
              if (write_latch_r && op_r == `OP_WR_SERIAL)
                serial[addr_r[2:0]] <= sh_nxt;
              addr_r <= addr_r + {{(AW-1){1'b0}}, 1'b1};
            end
          end
          S_WST:
          begin
            if (cnt_r == 5'h07)
            begin
              state_r <= S_IDLE;
              if (st_write_ok)
              begin
                status_lock_enable_r <= sh_nxt[`ST_LOCK_BIT];
                st_spare_r           <= sh_nxt[6:4];
                st_bp_r              <= sh_nxt[3:2];
              end
            end
          end
          S_RDAT, S_RST:
          begin
            if (cnt_r == 5'h07)
            begin
              cnt_r <= 5'h00;
              if (state_r == S_RST)
                out_r <= status_byte;
              else
              begin
                out_r  <= (op_r == `OP_RD_SERIAL) ?
                          serial[addr_r[2:0] + 3'h1] : mem[addr_r + {{(AW-1){1'b0}}, 1'b1}];
                addr_r <= addr_r + {{(AW-1){1'b0}}, 1'b1};
              end
            end
            else
              out_r <= {out_r[6:0], 1'b0};
          end
          default: state_r <= S_IDLE;
        endcase
      end
      // The first data bit is put out as soon as the read phase opens, so that it
      // stands before the first falling edge; later bits follow each fall.
      if (fall || (state_r == S_RDAT || state_r == S_RST) && !so_oe)
        so_o <= out_r[7];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Write buffer: two entries with valid and ready on both sides sit between the
// shifter and the array. The array accepts every cycle today, so the buffer never
// fills; the ready does not stall the shifter, so with a slower array a byte that meets a full buffer is dropped.
// A byte completes only every eight link clocks, far slower than the drain.
reg  [AW-1:0] wb_addr_r [0:1];
reg  [7:0]    wb_data_r [0:1];
reg           wb_head_r;
reg           wb_tail_r;
reg  [1:0]    wb_count_r;
wire          wb_in_valid  = rise && cs_d && state_r == S_WDAT && cnt_r == 5'h07 &&
                             write_latch_r && op_r == `OP_WRITE;
wire          wb_in_ready  = (wb_count_r != 2'h2);
wire          wb_out_valid = (wb_count_r != 2'h0);
wire          wb_out_ready = 1'b1;
wire          wb_push      = wb_in_valid & wb_in_ready;
wire          wb_pop       = wb_out_valid & wb_out_ready;

always @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    wb_head_r  <= 1'b0;
    wb_tail_r  <= 1'b0;
    wb_count_r <= 2'h0;
  end
  else
  begin
    if (wb_push)
      wb_tail_r <= ~wb_tail_r;
    if (wb_pop)
      wb_head_r <= ~wb_head_r;
    case ({wb_push, wb_pop})
      2'b10:   wb_count_r <= wb_count_r + 2'h1;
      2'b01:   wb_count_r <= wb_count_r - 2'h1;
      default: wb_count_r <= wb_count_r;
    endcase
  end
end

// Entries and array have no reset; the array models retained storage and is only
// ever written from the buffer, as a pure slave answering the master.
always @(posedge clk)
begin
  if (wb_push)
  begin
    wb_addr_r[wb_tail_r] <= addr_r;
    wb_data_r[wb_tail_r] <= sh_nxt;
  end
  if (wb_pop)
    mem[wb_addr_r[wb_head_r]] <= wb_data_r[wb_head_r];
end

endmodule // nvram_spi_slave_port

// ### include/nvram_spi_consts.vh
// Constants for the serial memory slave port.
`ifndef NVRAM_SPI_CONSTS_VH
`define NVRAM_SPI_CONSTS_VH
`define OP_SET_LATCH   8'h06
`define OP_CLR_LATCH   8'h04
`define OP_RD_STATUS   8'h05
`define OP_WR_STATUS   8'h01
`define OP_READ        8'h03
`define OP_WRITE       8'h02
`define OP_FAST_READ   8'h0B
`define OP_WR_SERIAL   8'hC2
`define OP_RD_SERIAL   8'hC3
`define ST_LOCK_BIT    7
`define ST_LATCH_BIT   1
`define STATUS_RESET   8'h00
`define ADDR_BITS      15
`define SERIAL_BYTES   8
`endif

// ### verif/nvram_spi_monitor.sv
// Pin level checks for the serial memory slave port.
`timescale 1ns/10ps
module nvram_spi_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pins and status.
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic pause_n,
  input wire logic wp_n,
  input wire logic selected_r,
  input wire logic write_latch_r,
  input wire logic status_lock_enable_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////
  sequence cs_open;
    $fell(cs_n) ##1 !cs_n [*8];
  endsequence
  sequence pause_held;
    !pause_n [*5];
  endsequence
  idle_float_a: assert property (cs_n [*5] |-> !so_oe)
    else $error("output driven while deselected");
  pause_float_a: assert property (pause_held |-> !so_oe)
    else $error("output driven during pause");
  select_track_a: assert property ($fell(cs_n) |-> ##[1:4] selected_r)
    else $error("select not seen");
  deselect_track_a: assert property ($rose(cs_n) |-> ##[1:4] !selected_r)
    else $error("deselect not seen");
  so_fall_a: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
    else $error("output changed while clock high");
  opcode_quiet_a: assert property (cs_open |-> !so_oe)
    else $error("output driven during opcode");
  latch_quiet_a: assert property (!selected_r [*6] |-> $stable(write_latch_r))
    else $error("latch moved while idle");
  lock_guard_a: assert property (!wp_n && status_lock_enable_r |=> status_lock_enable_r)
    else $error("protected lock cleared");
  lock_latch_a: assert property ($changed(status_lock_enable_r) |-> $past(write_latch_r))
    else $error("status written without latch");
  drive_select_a: assert property (so_oe |-> selected_r)
    else $error("output driven while not selected");
endmodule // nvram_spi_monitor

// ### verif/spi_master_model.sv
// Serial bus master model that drives the memory port pins.
`timescale 1ns/10ps
module spi_master_model (
  // Clock.
  input  wire logic clk,
  // Bus.
  output logic      cs_n = 1'b1,
  output logic      sck = 1'b0,
  output logic      si = 1'b0,
  output logic      pause_n = 1'b1,
  input  wire logic so_o,
  input  wire logic so_oe
);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////
  // A floated output reads as z, so a read outside the data phase cannot match.
  task automatic frame(input logic m, input int n, input logic [47:0] w,
                       input int pb, output logic [47:0] r);
    r = '0;
    sck <= m;
    tick(4);
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++)
    begin
      if (i == pb)
      begin
        pause_n <= 1'b0;
        tick(16);
        pause_n <= 1'b1;
        tick(4);
      end
      si <= w[47 - i];
      sck <= 1'b0;
      tick(4);
      sck <= 1'b1;
      tick(4);
      r = {r[46:0], so_oe ? so_o : 1'bz};
    end
    sck <= m;
    tick(4);
    cs_n <= 1'b1;
    si <= ~si;
    tick(8);
  endtask
endmodule // spi_master_model

// ### verif/test_nvram_spi_slave_port.sv
// Self-checking bench for the serial memory slave port.
`timescale 1ns/10ps
`include "nvram_spi_consts.vh"
module test_nvram_spi_slave_port;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wp_n = 1'b1;
  logic [47:0] r;
  wire         cs_n, sck, si, so_o, so_oe, pause_n;
  wire         selected_r, write_latch_r, status_lock_enable_r;
  int          errors = 0;
  int          samples_checked = 0;
  always #25 clk = ~clk;
  nvram_spi_slave_port i_dut (.clk, .rstn, .cs_n, .sck, .si, .so_o, .so_oe,
    .pause_n, .wp_n, .selected_r, .write_latch_r, .status_lock_enable_r);
  spi_master_model i_mst (.clk, .cs_n, .sck, .si, .pause_n, .so_o, .so_oe);
  ////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic op(input logic m, input int n, input logic [47:0] w);
    i_mst.frame(m, n, w, -1, r);
  endtask
  ////////////////////////
  task automatic t_latch;
    fork
      op(0, 8, {`OP_SET_LATCH, 40'h0});
      begin
        repeat (20) @(posedge clk);
        chk(selected_r, 1'b1);
      end
    join
    chk(selected_r, 1'b0);
    chk(write_latch_r, 1'b1);
    op(1, 8, {`OP_CLR_LATCH, 40'h0});
    chk(write_latch_r, 1'b0);
    op(0, 4, {`OP_SET_LATCH, 40'h0});
    chk(write_latch_r, 1'b0);
    $display("test latch done");
  endtask
  // Write in mode 0, read straight back in mode 3 with a pause mid-read.
  task automatic t_array;
    op(0, 8, {`OP_SET_LATCH, 40'h0});
    op(0, 40, {`OP_WRITE, 16'h7FFE, 16'hA53C, 8'h00});
    i_mst.frame(1, 40, {`OP_READ, 16'h7FFE, 16'h0, 8'h00}, 32, r);
    chk(r[15:0], 16'hA53C);
    chk(r[31:24], 16'h00ZZ);
    op(0, 8, {`OP_CLR_LATCH, 40'h0});
    op(0, 32, {`OP_WRITE, 16'h7FFE, 16'h1100, 8'h00});
    op(0, 32, {`OP_READ, 16'hFFFE, 16'h0, 8'h00});
    chk(r[7:0], 8'hA5);
    $display("test array done");
  endtask
  task automatic t_status;
    op(0, 8, {`OP_SET_LATCH, 40'h0});
    op(0, 16, {`OP_WR_STATUS, 8'h80, 32'h0});
    chk(status_lock_enable_r, 1'b1);
    op(1, 16, {`OP_RD_STATUS, 40'h0});
    chk(r[7:0], 8'h82);
    wp_n <= 1'b0;
    op(0, 8, {`OP_SET_LATCH, 40'h0});
    op(0, 16, {`OP_WR_STATUS, 8'h00, 32'h0});
    chk(status_lock_enable_r, 1'b1);
    wp_n <= 1'b1;
    op(0, 16, {`OP_WR_STATUS, 8'h00, 32'h0});
    chk(status_lock_enable_r, 1'b0);
    $display("test status done");
  endtask
  // Serial number round trip and refusal, then a fast read of the array in mode 3.
  task automatic t_serial;
    op(0, 8, {`OP_SET_LATCH, 40'h0});
    op(0, 40, {`OP_WR_SERIAL, 16'h0005, 16'hBEEF, 8'h00});
    op(1, 40, {`OP_RD_SERIAL, 16'h0005, 16'h0, 8'h00});
    chk(r[15:0], 16'hBEEF);
    op(0, 8, {`OP_CLR_LATCH, 40'h0});
    op(0, 40, {`OP_WR_SERIAL, 16'h0005, 16'h1234, 8'h00});
    op(0, 40, {`OP_RD_SERIAL, 16'h0005, 16'h0, 8'h00});
    chk(r[15:0], 16'hBEEF);
    op(1, 48, {`OP_FAST_READ, 16'h7FFE, 8'h00, 16'h0});
    chk(r[15:0], 16'hA53C);
    $display("test serial done");
  endtask
  ////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_latch;
    t_array;
    t_status;
    t_serial;
    conclude;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    conclude;
  end
endmodule // test_nvram_spi_slave_port
bind nvram_spi_slave_port nvram_spi_monitor i_mon (.clk, .rstn, .cs_n, .sck, .si,
  .so_o, .so_oe, .pause_n, .wp_n, .selected_r, .write_latch_r, .status_lock_enable_r);
